// file: dgpio_top.sv
// Two general purpose ports with direction control, port B pull-ups and port B pin-change events.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
//
// What this block does
// R1: Port A latch six bits; upper bits zero.
// R2: Port A direction one floats, zero drives.
// R3: Data read returns pins; write sets latch.
// R4: Writes are read-modify-write using sampled pins.
// R5: Port A bit 4 open-drain, feeds timer clock.
// R6: Three-bit analog field, resets to zero.
// R7: Analog-capable pins come up analog inputs.
// R8: Software keeps analog pins' direction bits set.
// R9: Direction registers reset to all ones.
// R10: Port B eight-bit bidirectional, same direction sense.
// R11: Cleared option bit 7 enables port B pull-ups.
// R12: Pull-up off while pin is an output.
// R13: Option register resets all ones, pull-ups off.
// R14: Bits 7..4 compared with last-read snapshot.
// R15: Only input pins join the change compare.
// R16: Mismatch keeps flag set; port access ends it.
// R17: Change event can wake the sleeping device.
// R18: Software avoids polling port B during change use.
// R19: Port B bit 0 is external interrupt input.
// R20: Port B latch kept across resets.
// R21: Edge select one means rising, zero falling.
module dgpio_top (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [dgpio_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic [dgpio_pkg::PA_W-1:0] PA_IN,
   output logic [dgpio_pkg::PA_W-1:0] PA_OUT,
   output logic [dgpio_pkg::PA_W-1:0] PA_OE,
   input wire logic [dgpio_pkg::PB_W-1:0] PB_IN,
   output logic [dgpio_pkg::PB_W-1:0] PB_OUT,
   output logic [dgpio_pkg::PB_W-1:0] PB_OE,
   output logic [dgpio_pkg::PB_W-1:0] PB_PULLUP,
   output logic [4:0] ANALOG_EN,
   output logic TIMER0_CLK,
   output logic CHANGE_FLAG,
   output logic EXT_FLAG,
   output logic WAKE
);

   // Returns the byte address of a register index.
   function automatic logic [dgpio_pkg::ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'b00, idx, 2'b00};
   endfunction : reg_addr

   // Analog mask over pins {5,3,2,1,0}; a cleared field makes them all analog.
   function automatic logic [4:0] analog_mask(input logic [2:0] cfg);
      case (cfg)
         3'h0: analog_mask = 5'h1f;
         3'h1: analog_mask = 5'h1f;
         3'h2: analog_mask = 5'h1f;
         3'h3: analog_mask = 5'h0b;
         3'h4: analog_mask = 5'h0b;
         3'h5: analog_mask = 5'h03;
         default: analog_mask = 5'h00;
      endcase
   endfunction : analog_mask

   // Input synchronisers: a change is accepted once stages two and three agree.
   dgpio_pkg::dgpio_pins_t sync1;
   dgpio_pkg::dgpio_pins_t sync2;
   dgpio_pkg::dgpio_pins_t sync3;
   dgpio_pkg::dgpio_pins_t pins;
   dgpio_pkg::dgpio_pins_t next_pins;

   always_comb begin
      for (int i = 0; i < $bits(next_pins); i++) begin
         next_pins[i] = (sync2[i] == sync3[i]) ? sync3[i] : pins[i];
      end
   end

   always_ff @(posedge CLK) begin
      sync1 <= {PA_IN, PB_IN};
      sync2 <= sync1;
      sync3 <= sync2;
      // Reset loads the filter from its last stage, so no false pin edge follows reset.
      if (SRST) begin
         pins <= sync3;
      end else begin
         pins <= next_pins;
      end
   end

   // Register state.
   logic [5:0] pa_latch;
   logic [7:0] pb_latch;
   logic [5:0] pa_dir;
   logic [7:0] pb_dir;
   logic [7:0] config_reg;
   logic [2:0] analog_cfg;
   dgpio_pkg::dgpio_irq_t irq;
   logic [3:0] change_snap;
   logic ext_prev;
   logic [31:0] rdata;
   logic [5:0] next_pa_latch;
   logic [7:0] next_pb_latch;
   logic [5:0] next_pa_dir;
   logic [7:0] next_pb_dir;
   logic [7:0] next_config_reg;
   logic [2:0] next_analog_cfg;
   dgpio_pkg::dgpio_irq_t next_irq;
   logic [3:0] next_change_snap;
   logic [31:0] next_rdata;

   logic setup;
   logic wr;
   logic hit_pa;
   logic hit_pb;
   logic hit_irq;
   logic hit_cfg;
   logic hit_pa_dir;
   logic hit_pb_dir;
   logic hit_an;
   logic mapped;
   logic [4:0] an_mask;
   logic [5:0] pa_view;
   logic [7:0] keep;
   logic mismatch;
   logic ext_edge;

   assign setup = PSEL && !PENABLE;
   assign wr = PSEL && PENABLE && PWRITE;
   assign hit_pa = PADDR == reg_addr(dgpio_pkg::IDX_PORT_A_DATA);
   assign hit_pb = PADDR == reg_addr(dgpio_pkg::IDX_PORT_B_DATA);
   assign hit_irq = PADDR == reg_addr(dgpio_pkg::IDX_IRQ_CONTROL_REG);
   assign hit_cfg = PADDR == reg_addr(dgpio_pkg::IDX_PULLUP_EDGE_PRESCALE_CONFIG);
   assign hit_pa_dir = PADDR == reg_addr(dgpio_pkg::IDX_PORT_A_DIRECTION);
   assign hit_pb_dir = PADDR == reg_addr(dgpio_pkg::IDX_PORT_B_DIRECTION);
   assign hit_an = PADDR == reg_addr(dgpio_pkg::IDX_ANALOG_PIN_CONFIG);
   assign mapped = hit_pa || hit_pb || hit_irq || hit_cfg || hit_pa_dir || hit_pb_dir || hit_an;
   assign keep = PWDATA[dgpio_pkg::DATA_KEEP_LO +: 8];

   assign an_mask = analog_mask(analog_cfg); // [R6]
   // Analog pins read as zero through the digital path.
   assign pa_view = pins.pa & ~{an_mask[4], 1'b0, an_mask[3:0]};

   // Only inputs among bits 7..4 are compared against the snapshot.
   assign mismatch = |((pins.pb[7:4] ^ change_snap) & pb_dir[7:4]); // [R14] [R15]
   // Edge select high picks a rising edge, low a falling edge.
   assign ext_edge = config_reg[dgpio_pkg::CFG_EXT_IRQ_EDGE_SELECT]
      ? (pins.pb[dgpio_pkg::PB_EXT_BIT] && !ext_prev)
      : (!pins.pb[dgpio_pkg::PB_EXT_BIT] && ext_prev); // [R19] [R21]

   always_comb begin
      next_pa_latch = pa_latch;
      next_pb_latch = pb_latch;
      next_pa_dir = pa_dir;
      next_pb_dir = pb_dir;
      next_config_reg = config_reg;
      next_analog_cfg = analog_cfg;
      next_irq = irq;
      next_change_snap = change_snap;
      next_rdata = rdata;
      if (setup) begin
         next_rdata = '0;
         if (hit_pa) begin
            next_rdata[5:0] = pa_view; // [R1] [R3]
         end else if (hit_pb) begin
            next_rdata[7:0] = pins.pb; // [R3]
            next_change_snap = pins.pb[7:4]; // [R16]
         end else if (hit_irq) begin
            next_rdata[4:0] = {irq.ext_en, irq.change_en, 1'b0, irq.ext_flag, irq.change_flag};
         end else if (hit_cfg) begin
            next_rdata[7:0] = config_reg;
         end else if (hit_pa_dir) begin
            next_rdata[5:0] = pa_dir; // [R1]
         end else if (hit_pb_dir) begin
            next_rdata[7:0] = pb_dir;
         end else if (hit_an) begin
            next_rdata[2:0] = analog_cfg;
         end
      end
      if (wr) begin
         if (hit_pa) begin
            // Kept bits take the sampled pin level, as a bit operation would.
            next_pa_latch = (pa_view & keep[5:0]) | (PWDATA[5:0] & ~keep[5:0]); // [R4] [R3]
         end else if (hit_pb) begin
            next_pb_latch = (pins.pb & keep) | (PWDATA[7:0] & ~keep); // [R4] [R3]
            next_change_snap = pins.pb[7:4]; // [R16]
         end else if (hit_irq) begin
            next_irq.change_flag = PWDATA[dgpio_pkg::IRQ_CHANGE_FLAG];
            next_irq.ext_flag = PWDATA[dgpio_pkg::IRQ_EXT_FLAG];
            next_irq.change_en = PWDATA[dgpio_pkg::IRQ_CHANGE_EN];
            next_irq.ext_en = PWDATA[dgpio_pkg::IRQ_EXT_EN];
         end else if (hit_cfg) begin
            next_config_reg = PWDATA[7:0];
         end else if (hit_pa_dir) begin
            next_pa_dir = PWDATA[5:0];
         end else if (hit_pb_dir) begin
            next_pb_dir = PWDATA[7:0];
         end else if (hit_an) begin
            next_analog_cfg = PWDATA[2:0];
         end
      end
      // Hardware set wins over a software clear in the same cycle.
      if (mismatch) begin
         next_irq.change_flag = 1'b1; // [R14] [R16]
      end
      if (ext_edge) begin
         next_irq.ext_flag = 1'b1; // [R19]
      end
   end

   always_ff @(posedge CLK) begin
      // The port B latch and snapshot are left alone by reset.
      pb_latch <= next_pb_latch; // [R20]
      change_snap <= next_change_snap;
      // The edge detector tracks the filtered pin through reset as well.
      ext_prev <= pins.pb[dgpio_pkg::PB_EXT_BIT]; // [R19]
      if (SRST) begin
         pa_latch <= dgpio_pkg::RST_PORT_A_LATCH;
         pa_dir <= dgpio_pkg::RST_PORT_A_DIRECTION; // [R9] [R7]
         pb_dir <= dgpio_pkg::RST_PORT_B_DIRECTION; // [R9]
         config_reg <= dgpio_pkg::RST_CONFIG; // [R13]
         analog_cfg <= dgpio_pkg::RST_ANALOG_CFG; // [R6] [R7]
         irq <= dgpio_pkg::RST_IRQ_CTRL[3:0];
         rdata <= '0;
      end else begin
         pa_latch <= next_pa_latch;
         pa_dir <= next_pa_dir;
         pb_dir <= next_pb_dir;
         config_reg <= next_config_reg;
         analog_cfg <= next_analog_cfg;
         irq <= next_irq;
         rdata <= next_rdata;
      end
   end

   // Bus answer: one access cycle, read data captured in the setup cycle.
   assign PREADY = PSEL && PENABLE;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign PRDATA = rdata;

   // Pin drivers. A set direction bit floats the pin.
   always_comb begin
      PA_OUT = pa_latch; // [R2]
      PA_OE = ~pa_dir; // [R2] [R8]
      // Bit 4 only ever pulls low.
      PA_OUT[dgpio_pkg::PA_TIMER_BIT] = 1'b0; // [R5]
      PA_OE[dgpio_pkg::PA_TIMER_BIT] = !pa_dir[dgpio_pkg::PA_TIMER_BIT]
         && !pa_latch[dgpio_pkg::PA_TIMER_BIT]; // [R5]
      PB_OUT = pb_latch & ~pb_dir; // [R10]
      PB_OE = ~pb_dir; // [R10]
      PB_PULLUP = config_reg[dgpio_pkg::CFG_PULLUP_DISABLE_N] ? 8'h00 : pb_dir; // [R11] [R12]
   end

   assign ANALOG_EN = an_mask; // [R7]
   assign TIMER0_CLK = pins.pa[dgpio_pkg::PA_TIMER_BIT]; // [R5]
   assign CHANGE_FLAG = irq.change_flag;
   assign EXT_FLAG = irq.ext_flag;
   assign WAKE = irq.change_flag && irq.change_en; // [R17]

endmodule : dgpio_top

// file: dgpio_pkg.sv
// Shared constants and carrier types for the dual port I/O block.
package dgpio_pkg;

   localparam int ADDR_W = 12;
   localparam int PA_W = 6;
   localparam int PB_W = 8;

   // Register indices; the byte address on the bus is four times the index.
   localparam logic [7:0] IDX_PORT_A_DATA = 8'h05;
   localparam logic [7:0] IDX_PORT_B_DATA = 8'h06;
   localparam logic [7:0] IDX_IRQ_CONTROL_REG = 8'h0b;
   localparam logic [7:0] IDX_PULLUP_EDGE_PRESCALE_CONFIG = 8'h81;
   localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h85;
   localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h86;
   localparam logic [7:0] IDX_ANALOG_PIN_CONFIG = 8'h9f;

   // Reset values.
   localparam logic [5:0] RST_PORT_A_DIRECTION = 6'h3f;
   localparam logic [7:0] RST_PORT_B_DIRECTION = 8'hff;
   localparam logic [7:0] RST_CONFIG = 8'hff;
   localparam logic [2:0] RST_ANALOG_CFG = 3'h0;
   localparam logic [5:0] RST_PORT_A_LATCH = 6'h00;
   localparam logic [4:0] RST_IRQ_CTRL = 5'h00;

   // Field positions.
   localparam int CFG_PULLUP_DISABLE_N = 7;
   localparam int CFG_EXT_IRQ_EDGE_SELECT = 6;
   localparam int IRQ_CHANGE_FLAG = 0;
   localparam int IRQ_EXT_FLAG = 1;
   localparam int IRQ_CHANGE_EN = 3;
   localparam int IRQ_EXT_EN = 4;
   localparam int PA_TIMER_BIT = 4;
   localparam int PB_EXT_BIT = 0;
   localparam int PB_CHANGE_LO = 4;
   localparam int DATA_KEEP_LO = 8;

   typedef struct packed {
      logic [PA_W-1:0] pa;
      logic [PB_W-1:0] pb;
   } dgpio_pins_t;

   typedef struct packed {
      logic change_en;
      logic ext_en;
      logic ext_flag;
      logic change_flag;
   } dgpio_irq_t;

endpackage : dgpio_pkg

// file: dgpio_props.sv
// Concurrent checks on the port behaviour of the dual port I/O block.
`timescale 1ns/10ps
module dgpio_chk (
   input wire logic CLK,
   input wire logic SRST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [dgpio_pkg::ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [dgpio_pkg::PA_W-1:0] PA_OUT,
   input wire logic [dgpio_pkg::PA_W-1:0] PA_OE,
   input wire logic [dgpio_pkg::PB_W-1:0] PB_OUT,
   input wire logic [dgpio_pkg::PB_W-1:0] PB_OE,
   input wire logic [dgpio_pkg::PB_W-1:0] PB_PULLUP,
   input wire logic [4:0] ANALOG_EN,
   input wire logic CHANGE_FLAG,
   input wire logic WAKE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence apb_setup;
      PSEL && !PENABLE;
   endsequence
   sequence apb_access;
      apb_setup ##1 PSEL && PENABLE;
   endsequence
   sequence pa_dir_write;
      PSEL && PENABLE && PWRITE
         && PADDR == {2'b00, dgpio_pkg::IDX_PORT_A_DIRECTION, 2'b00};
   endsequence
   sequence pa_oe_follows;
      {PA_OE[5], PA_OE[3:0]} == ~{$past(PWDATA[5]), $past(PWDATA[3:0])};
   endsequence
   chk_ready_access: assert property (apb_access |-> PREADY ##1 !PREADY)
      else $error("ready wrong around access phase");
   chk_err_access: assert property (PSLVERR |-> PSEL && PENABLE)
      else $error("error response outside access phase");
   chk_pa_drive: assert property (pa_dir_write |=> pa_oe_follows)
      else $error("port a enables differ from written direction");
   chk_pa_open: assert property (!PA_OUT[dgpio_pkg::PA_TIMER_BIT])
      else $error("timer pin driven high");
   chk_pb_drive: assert property ((PB_OUT & ~PB_OE) == 8'h00)
      else $error("port b drives a released pin");
   chk_pullup_out: assert property ((PB_PULLUP & PB_OE) == 8'h00)
      else $error("pull-up on an output pin");
   chk_wake_flag: assert property (WAKE |-> CHANGE_FLAG)
      else $error("wake without change flag");
   chk_reset_dirs: assert property ($fell(SRST) |-> PA_OE == 6'h00 && PB_OE == 8'h00)
      else $error("pins driven after reset");
   chk_reset_analog: assert property ($fell(SRST) |-> ANALOG_EN == 5'h1f)
      else $error("analog pins not selected after reset");
endmodule : dgpio_chk
bind dgpio_top dgpio_chk u_chk (.CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .PA_OUT(PA_OUT), .PA_OE(PA_OE), .PB_OUT(PB_OUT),
   .PB_OE(PB_OE), .PB_PULLUP(PB_PULLUP), .ANALOG_EN(ANALOG_EN), .CHANGE_FLAG(CHANGE_FLAG),
   .WAKE(WAKE));

// file: dgpio_pins.sv
// Model of the external pins and board circuitry on both ports.
`timescale 1ns/10ps
module dgpio_pins (
   input wire logic clk,
   input wire logic [5:0] pa_out,
   input wire logic [5:0] pa_oe,
   input wire logic [5:0] ext_pa,
   input wire logic [5:0] ext_pa_en,
   input wire logic [7:0] pb_out,
   input wire logic [7:0] pb_oe,
   input wire logic [7:0] pb_pullup,
   input wire logic [7:0] ext_pb,
   input wire logic [7:0] ext_pb_en,
   output logic [5:0] pa_in,
   output logic [7:0] pb_in
);
   logic [5:0] pa_last;
   logic [7:0] pb_last;
   always @(posedge clk) begin
      pa_last <= pa_in;
      pb_last <= pb_in;
   end
   // A line nobody drives floats, so it shows the inverse of its last level, unless its port B pull-up holds it high.
   always_comb begin
      pa_in = (pa_oe & pa_out) | (~pa_oe & ext_pa_en & ext_pa) | (~pa_oe & ~ext_pa_en & ~pa_last);
      pb_in = (pb_oe & pb_out) | (~pb_oe & ext_pb_en & ext_pb) | (~pb_oe & ~ext_pb_en & (pb_pullup | ~pb_last));
   end
endmodule : dgpio_pins

// file: dgpio_tb.sv
// Self-checking testbench of the dual port I/O block.
`timescale 1ns/10ps
module testbench;
   localparam logic [7:0] ix_pa = dgpio_pkg::IDX_PORT_A_DATA;
   localparam logic [7:0] ix_pb = dgpio_pkg::IDX_PORT_B_DATA;
   localparam logic [7:0] ix_irq = dgpio_pkg::IDX_IRQ_CONTROL_REG;
   localparam logic [7:0] ix_opt = dgpio_pkg::IDX_PULLUP_EDGE_PRESCALE_CONFIG;
   localparam logic [7:0] ix_dira = dgpio_pkg::IDX_PORT_A_DIRECTION;
   localparam logic [7:0] ix_dirb = dgpio_pkg::IDX_PORT_B_DIRECTION;
   localparam logic [7:0] ix_ana = dgpio_pkg::IDX_ANALOG_PIN_CONFIG;
   logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, r;
   logic pready, pslverr, err, timer0_clk, change_flag, ext_flag, wake;
   logic [5:0] pa_in, pa_out, pa_oe, ext_pa = 6'h00, ext_pa_en = 6'h3f;
   logic [7:0] pb_in, pb_out, pb_oe, pb_pullup, ext_pb = 8'h00, ext_pb_en = 8'hff;
   logic [4:0] analog_en;
   int num_errors = 0, tests_run = 0, seed = 51;
   int mdl[int];
   always #2 clk = ~clk;
   dgpio_top dut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe), .PB_IN(pb_in), .PB_OUT(pb_out),
      .PB_OE(pb_oe), .PB_PULLUP(pb_pullup), .ANALOG_EN(analog_en), .TIMER0_CLK(timer0_clk),
      .CHANGE_FLAG(change_flag), .EXT_FLAG(ext_flag), .WAKE(wake));
   dgpio_pins u_pins (.clk(clk), .pa_out(pa_out), .pa_oe(pa_oe), .ext_pa(ext_pa),
      .ext_pa_en(ext_pa_en), .pb_out(pb_out), .pb_oe(pb_oe), .pb_pullup(pb_pullup),
      .ext_pb(ext_pb), .ext_pb_en(ext_pb_en), .pa_in(pa_in), .pb_in(pb_in));
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= {2'b00, idx, 2'b00};
      pwrite <= wr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] idx, input logic [31:0] v);
      apb(idx, 1'b1, v);
      mdl[idx] = v & (idx == ix_dira ? 32'h0000_003f : idx == ix_ana ? 32'h0000_0007 : 32'h0000_00ff);
   endtask : wr
   task automatic rb(input logic [7:0] idx);
      apb(idx, 1'b0, 32'h0000_0000);
      chk("register readback", rd, mdl[idx]);
   endtask : rb
   task automatic w(input int n);
      repeat (n) @(posedge clk);
   endtask : w
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   initial begin
      mdl[ix_opt] = 32'h0000_00ff;
      mdl[ix_dira] = 32'h0000_003f;
      mdl[ix_dirb] = 32'h0000_00ff;
      mdl[ix_ana] = 32'h0000_0000;
      ext_pa <= 6'h3f;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      foreach (mdl[k]) rb(8'(k));
      chk("analog select", analog_en, 5'h1f);
      apb(8'h40, 1'b0, 32'h0000_0000);
      chk("unmapped error", err, 1'b1);
      chk("unmapped data", rd, 32'h0000_0000);
      apb(ix_pa, 1'b0, 32'h0000_0000);
      chk("analog pins read", rd, 32'h0000_0010);
      wr(ix_ana, 32'h0000_0003);
      w(1);
      chk("analog select", analog_en, 5'h0b);
      wr(ix_ana, 32'h0000_0006);
      w(1);
      chk("analog select", analog_en, 5'h00);
      r = $random(seed);
      ext_pa <= r[5:0] | 6'h10;
      wr(ix_dira, 32'h0000_000f);
      w(6);
      wr(ix_pa, {16'h0000, 8'h0f, r[15:8]});
      wr(ix_dira, 32'h0000_00ff);
      rb(ix_dira);
      wr(ix_dira, 32'h0000_0000);
      w(6);
      chk("port a drive", pa_out, {r[13], 1'b0, r[3:0]});
      chk("timer clock", timer0_clk, r[12]);
      chk("port a enables", pa_oe, {1'b1, ~r[12], 4'hf});
      apb(ix_pa, 1'b0, 32'h0000_0000);
      chk("port a read", rd, {r[13:12], r[3:0]});
      wr(ix_opt, 32'h0000_007f);
      wr(ix_dirb, 32'h0000_00f0);
      w(1);
      chk("pull-ups", pb_pullup, 8'hf0);
      chk("port b enables", pb_oe, 8'h0f);
      ext_pb <= 8'h50;
      ext_pb_en <= 8'hf0;
      wr(ix_pb, 32'h0000_00a5);
      w(6);
      chk("port b drive", pb_out, 8'h05);
      apb(ix_pb, 1'b0, 32'h0000_0000);
      chk("port b read", rd, 32'h0000_0055);
      wr(ix_irq, 32'h0000_0008);
      w(2);
      chk("change idle", change_flag, 1'b0);
      ext_pb <= 8'h70;
      w(6);
      chk("change set", change_flag, 1'b1);
      chk("wake", wake, 1'b1);
      wr(ix_irq, 32'h0000_0008);
      w(2);
      chk("change held", change_flag, 1'b1);
      apb(ix_pb, 1'b0, 32'h0000_0000);
      wr(ix_irq, 32'h0000_0008);
      w(2);
      chk("change cleared", change_flag, 1'b0);
      wr(ix_dirb, 32'h0000_000f);
      w(6);
      chk("outputs excluded", change_flag, 1'b0);
      ext_pb_en <= 8'h0f;
      for (int e = 0; e < 2; e++) begin
         wr(ix_opt, {24'h00_0000, 1'b0, e[0], 6'h3f});
         ext_pb <= {7'h00, ~e[0]};
         w(6);
         wr(ix_irq, 32'h0000_0000);
         ext_pb <= {7'h00, e[0]};
         w(6);
         chk("ext active edge", ext_flag, 1'b1);
         wr(ix_irq, 32'h0000_0000);
         ext_pb <= {7'h00, ~e[0]};
         w(6);
         chk("ext other edge", ext_flag, 1'b0);
      end
      // A second reset restores the registers but leaves the port B latch alone.
      wr(ix_pb, 32'h0000_003c);
      srst <= 1'b1;
      w(2);
      srst <= 1'b0;
      mdl[ix_opt] = 32'h0000_00ff;
      mdl[ix_dira] = 32'h0000_003f;
      mdl[ix_dirb] = 32'h0000_00ff;
      mdl[ix_ana] = 32'h0000_0000;
      rb(ix_opt);
      rb(ix_dira);
      rb(ix_dirb);
      rb(ix_ana);
      chk("analog select", analog_en, 5'h1f);
      wr(ix_dirb, 32'h0000_0000);
      w(1);
      chk("latch kept", pb_out, 8'h3c);
      final_report;
   end
   // The whole sequence needs well under a thousand cycles; this cuts a hang short.
   initial begin
      #100000;
      num_errors++;
      final_report;
   end
endmodule : testbench
